// ===== logic/tdeu_pkg.sv
package tdeu_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] TDEU_ADDR_PAD_CTRL   = 8'h22;
  localparam logic [7:0] TDEU_ADDR_TAP_CFG    = 8'h38;
  localparam logic [7:0] TDEU_ADDR_TAP_SRC    = 8'h39;
  localparam logic [7:0] TDEU_ADDR_THR_XY     = 8'h3b;
  localparam logic [7:0] TDEU_ADDR_THR_Z      = 8'h3c;
  localparam logic [7:0] TDEU_ADDR_MAX_LEN    = 8'h3d;
  localparam logic [7:0] TDEU_ADDR_QUIET      = 8'h3e;
  localparam logic [7:0] TDEU_ADDR_SPAN       = 8'h3f;

  // ==========================================================
  // reset values
  localparam logic [7:0] TDEU_RST_PAD_CTRL    = 8'h00;
  localparam logic [7:0] TDEU_RST_TAP_CFG     = 8'h00;
  localparam logic [7:0] TDEU_RST_THR         = 8'h00;
  localparam logic [7:0] TDEU_RST_MAX_LEN     = 8'h00;
  localparam logic [7:0] TDEU_RST_QUIET       = 8'h00;
  localparam logic [7:0] TDEU_RST_SPAN        = 8'h00;
  localparam logic       TDEU_RST_PAD_O       = 1'b0;
  localparam logic       TDEU_RST_PAD_OE      = 1'b1;

  // ==========================================================
  // field positions
  localparam int TDEU_POL_BIT      = 7;
  localparam int TDEU_DRV_BIT      = 6;
  localparam int TDEU_SEL_TWO_LSB  = 3;
  localparam int TDEU_SEL_ONE_LSB  = 0;
  localparam int TDEU_HOLD_BIT     = 6;
  localparam int TDEU_PEND_BIT     = 6;
  localparam int TDEU_Y_LEVEL_LSB  = 4;
  localparam int TDEU_X_LEVEL_LSB  = 0;

  // ==========================================================
  // pad select codes
  localparam logic [2:0] TDEU_SEL_GND      = 3'h0;
  localparam logic [2:0] TDEU_SEL_MOT_ONE  = 3'h1;
  localparam logic [2:0] TDEU_SEL_MOT_TWO  = 3'h2;
  localparam logic [2:0] TDEU_SEL_MOT_ANY  = 3'h3;
  localparam logic [2:0] TDEU_SEL_DRDY     = 3'h4;
  localparam logic [2:0] TDEU_SEL_TAP      = 3'h7;

  // ==========================================================
  // timing
  localparam int TDEU_CLK_HZ       = 125000000;
  localparam int TDEU_HALF_MS_US   = 500;
  localparam int TDEU_HALF_MS_CYC  = TDEU_CLK_HZ / 1000000 * TDEU_HALF_MS_US;

endpackage

// ===== logic/tdeu_axis_detect.sv
`timescale 1ns/10ps
`default_nettype none
module tdeu_axis_detect
  import tdeu_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       tick_half,
  input  wire logic       tick_ms,
  input  wire logic [7:0] accel_mag,
  input  wire logic [3:0] level,
  input  wire logic       dbl_mode,
  input  wire logic [7:0] max_len,
  input  wire logic [7:0] quiet_ms,
  input  wire logic [7:0] span_ms,
  output logic            single_hit,
  output logic            double_hit
);

  typedef enum logic [2:0] {IDLE, PULSE1, QUIET, WAITW, PULSE2, DRAIN} tdeu_st_e;

  tdeu_st_e    st;
  tdeu_st_e    next_st;
  logic [8:0]  cnt;
  logic [8:0]  next_cnt;
  logic        next_single;
  logic        next_double;
  logic        above;

  // ==========================================================
  // threshold compare, code n is n half-g; accel in half-g too
  assign above = accel_mag > {4'h0, level};

  // ==========================================================
  // detection sequence
  always_comb
  begin
    next_st     = st;
    next_cnt    = cnt;
    next_single = 1'b0;
    next_double = 1'b0;
    case (st)
      IDLE:
      begin
        next_cnt = 9'h000;
        if (above)
          next_st = PULSE1;
      end
      PULSE1, PULSE2:
      begin
        if (!above)
        begin
          // fall inside max length counts as a tap
          if (st == PULSE2)
          begin
            next_double = 1'b1;
            next_st     = IDLE;
          end
          else if (dbl_mode)
          begin
            next_st  = QUIET;
            next_cnt = 9'h000;
          end
          else
          begin
            next_single = 1'b1;
            next_st     = IDLE;
          end
          if (st == PULSE1)
            next_single = 1'b1;
        end
        else if ({1'b0, max_len} <= cnt)
          next_st = DRAIN;
        else if (tick_half)
          next_cnt = cnt + 9'h001;
      end
      QUIET:
      begin
        // detection disabled while quiet time runs
        if ({1'b0, quiet_ms} <= cnt)
        begin
          next_cnt = 9'h000;
          next_st  = above ? PULSE2 : WAITW;
        end
        else if (tick_ms)
          next_cnt = cnt + 9'h001;
      end
      WAITW:
      begin
        if (above)
        begin
          next_cnt = 9'h000;
          next_st  = PULSE2;
        end
        else if ({1'b0, span_ms} <= cnt)
          next_st = IDLE;
        else if (tick_ms)
          next_cnt = cnt + 9'h001;
      end
      DRAIN:
      begin
        // re-arm only after a fall, so an overlong pulse never restarts
        if (!above)
          next_st = IDLE;
      end
      default:
      begin
        next_st  = IDLE;
        next_cnt = 9'h000;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st         <= IDLE;
      cnt        <= 9'h000;
      single_hit <= 1'b0;
      double_hit <= 1'b0;
    end
    else if (clk_en)
    begin
      st         <= next_st;
      cnt        <= next_cnt;
      single_hit <= next_single;
      double_hit <= next_double;
    end
  end

endmodule
`default_nettype wire

// ===== logic/tdeu_top.sv
// Operation
// - tap_irq_pending bit sets when any enabled tap event raised an interrupt; resets 0.
// - source register holds single/double flags for x, y, z; reset 0.
// - xy threshold: y level upper nibble, x level lower nibble, reset zero.
// - z threshold: z level lower nibble, upper nibble unused, reset zero.
// - threshold codes are unsigned half-g steps, 1 = 0.5 g, 15 = 7.5 g.
// - detection starts when axis acceleration rises above its threshold.
// - max length register spans 0 to 127.5 ms in 0.5 ms steps.
// - tap counts only if acceleration falls below within max length.
// - double mode: after first tap detection off for quiet time, 1 ms steps.
// - second tap must start within span after quiet time, 1 ms steps.
// - polarity bit: 0 pads active high, 1 active low; reset 0.
// - driver bit: 0 push-pull, 1 open-drain; reset 0.
// - 3-bit field selects source for second pad; reset zero.
// - select codes: gnd, motion one, motion two, either, data ready, tap.
// - hold clear: irq lasts quiet time; hold set: until source read.
// - per-axis single/double enables gate which events raise the interrupt.
// - second tap starts on crossing in span or still above at quiet end.
`timescale 1ns/10ps
`default_nettype none
module tdeu_top
  import tdeu_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] accel_x,
  input  wire logic [7:0] accel_y,
  input  wire logic [7:0] accel_z,
  input  wire logic       motion_source_one,
  input  wire logic       motion_source_two,
  input  wire logic       data_ready,
  output logic            irq_pad_one_o,
  output logic            irq_pad_one_oe,
  output logic            irq_pad_two_o,
  output logic            irq_pad_two_oe
);

  logic [7:0]  irq_pad_control;
  logic [7:0]  tap_cfg;
  logic [7:0]  tap_threshold_xy;
  logic [7:0]  tap_threshold_z;
  logic [7:0]  tap_max_length;
  logic [7:0]  tap_quiet_time;
  logic [7:0]  second_tap_span;
  logic [5:0]  tap_flags;
  logic        tap_irq_pending;
  logic [7:0]  next_pad_ctrl;
  logic [7:0]  next_cfg;
  logic [7:0]  next_thr_xy;
  logic [7:0]  next_thr_z;
  logic [7:0]  next_max_len;
  logic [7:0]  next_quiet;
  logic [7:0]  next_span;
  logic [5:0]  next_flags;
  logic        next_pending;
  logic [15:0] half_cnt;
  logic [15:0] next_half_cnt;
  logic        ms_phase;
  logic        next_ms_phase;
  logic        tick_half;
  logic        tick_ms;
  logic [8:0]  hold_cnt;
  logic [8:0]  next_hold_cnt;
  logic [5:0]  hits;
  logic [5:0]  gated;
  logic        dbl_any;
  logic        src_read;
  logic        tap_line;
  logic [7:0]  next_rdata;
  logic [2:0]  mot_s1;
  logic [2:0]  mot_s2;
  logic [7:0]  axis_mag [3];
  logic [3:0]  axis_lvl [3];

  // ==========================================================
  // pad source decode, shared by both pads
  function automatic logic pad_sel(input logic [2:0] sel, input logic tap);
    case (sel)
      TDEU_SEL_GND:     pad_sel = 1'b0;
      TDEU_SEL_MOT_ONE: pad_sel = mot_s2[0];
      TDEU_SEL_MOT_TWO: pad_sel = mot_s2[1];
      TDEU_SEL_MOT_ANY: pad_sel = mot_s2[0] | mot_s2[1];
      TDEU_SEL_DRDY:    pad_sel = mot_s2[2];
      TDEU_SEL_TAP:     pad_sel = tap;
      default:          pad_sel = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers for outside event lines
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mot_s1 <= 3'h0;
      mot_s2 <= 3'h0;
    end
    else if (clk_en)
    begin
      mot_s1 <= {data_ready, motion_source_two, motion_source_one};
      mot_s2 <= mot_s1;
    end
  end

  // ==========================================================
  // time base
  always_comb
  begin
    tick_half     = (half_cnt == 16'(TDEU_HALF_MS_CYC - 1));
    tick_ms       = tick_half & ms_phase;
    next_half_cnt = tick_half ? 16'h0000 : half_cnt + 16'h0001;
    next_ms_phase = tick_half ? ~ms_phase : ms_phase;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      half_cnt <= 16'h0000;
      ms_phase <= 1'b0;
    end
    else if (clk_en)
    begin
      half_cnt <= next_half_cnt;
      ms_phase <= next_ms_phase;
    end
  end

  // ==========================================================
  // per-axis detectors
  assign axis_mag[0] = accel_x;
  assign axis_mag[1] = accel_y;
  assign axis_mag[2] = accel_z;
  assign axis_lvl[0] = tap_threshold_xy[TDEU_X_LEVEL_LSB +: 4];
  assign axis_lvl[1] = tap_threshold_xy[TDEU_Y_LEVEL_LSB +: 4];
  assign axis_lvl[2] = tap_threshold_z[3:0];

  genvar ax;
  generate
    for (ax = 0; ax < 3; ax++)
    begin : g_axis
      tdeu_axis_detect u_det (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .clk_en     (clk_en),
        .tick_half  (tick_half),
        .tick_ms    (tick_ms),
        .accel_mag  (axis_mag[ax]),
        .level      (axis_lvl[ax]),
        .dbl_mode   (tap_cfg[2*ax+1]),
        .max_len    (tap_max_length),
        .quiet_ms   (tap_quiet_time),
        .span_ms    (second_tap_span),
        .single_hit (hits[2*ax]),
        .double_hit (hits[2*ax+1])
      );
    end
  endgenerate

  // ==========================================================
  // registers and source flags
  assign src_read = reg_rd && (reg_addr == TDEU_ADDR_TAP_SRC);
  assign gated    = hits & tap_cfg[5:0];
  assign dbl_any  = |(tap_cfg[5:0] & 6'h2a);
  assign tap_line = tap_irq_pending && (tap_cfg[TDEU_HOLD_BIT] || hold_cnt != 9'h000);

  always_comb
  begin
    next_pad_ctrl = irq_pad_control;
    next_cfg      = tap_cfg;
    next_thr_xy   = tap_threshold_xy;
    next_thr_z    = tap_threshold_z;
    next_max_len  = tap_max_length;
    next_quiet    = tap_quiet_time;
    next_span     = second_tap_span;
    next_flags    = tap_flags;
    next_pending  = tap_irq_pending;
    next_hold_cnt = hold_cnt;
    if (reg_wr)
    begin
      case (reg_addr)
        TDEU_ADDR_PAD_CTRL: next_pad_ctrl = reg_wdata;
        TDEU_ADDR_TAP_CFG:  next_cfg      = {1'b0, reg_wdata[6:0]};
        TDEU_ADDR_THR_XY:   next_thr_xy   = reg_wdata;
        TDEU_ADDR_THR_Z:    next_thr_z    = {4'h0, reg_wdata[3:0]};
        TDEU_ADDR_MAX_LEN:  next_max_len  = reg_wdata;
        TDEU_ADDR_QUIET:    next_quiet    = reg_wdata;
        TDEU_ADDR_SPAN:     next_span     = reg_wdata;
        default:            next_pad_ctrl = irq_pad_control;
      endcase
    end
    // hold set: read clears; hold clear: quiet-time timer ends it
    if (src_read && tap_cfg[TDEU_HOLD_BIT])
    begin
      next_flags   = 6'h00;
      next_pending = 1'b0;
    end
    if (!tap_cfg[TDEU_HOLD_BIT] && tap_irq_pending)
    begin
      if (hold_cnt == 9'h000)
        next_pending = 1'b0;
      else if (tick_ms)
        next_hold_cnt = hold_cnt - 9'h001;
    end
    // a new event wins over a clearing read
    if (|gated)
    begin
      next_flags    = next_flags | gated;
      next_pending  = 1'b1;
      next_hold_cnt = {1'b0, tap_quiet_time} + (dbl_any ? 9'h000 : 9'h001);
    end
  end

  always_comb
  begin
    case (reg_addr)
      TDEU_ADDR_PAD_CTRL: next_rdata = irq_pad_control;
      TDEU_ADDR_TAP_CFG:  next_rdata = tap_cfg;
      TDEU_ADDR_TAP_SRC:  next_rdata = {1'b0, tap_irq_pending, tap_flags};
      TDEU_ADDR_THR_XY:   next_rdata = tap_threshold_xy;
      TDEU_ADDR_THR_Z:    next_rdata = tap_threshold_z;
      TDEU_ADDR_MAX_LEN:  next_rdata = tap_max_length;
      TDEU_ADDR_QUIET:    next_rdata = tap_quiet_time;
      TDEU_ADDR_SPAN:     next_rdata = second_tap_span;
      default:            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_pad_control  <= TDEU_RST_PAD_CTRL;
      tap_cfg          <= TDEU_RST_TAP_CFG;
      tap_threshold_xy <= TDEU_RST_THR;
      tap_threshold_z  <= TDEU_RST_THR;
      tap_max_length   <= TDEU_RST_MAX_LEN;
      tap_quiet_time   <= TDEU_RST_QUIET;
      second_tap_span  <= TDEU_RST_SPAN;
      tap_flags        <= 6'h00;
      tap_irq_pending  <= 1'b0;
      hold_cnt         <= 9'h000;
      reg_rdata        <= 8'h00;
    end
    else if (clk_en)
    begin
      irq_pad_control  <= next_pad_ctrl;
      tap_cfg          <= next_cfg;
      tap_threshold_xy <= next_thr_xy;
      tap_threshold_z  <= next_thr_z;
      tap_max_length   <= next_max_len;
      tap_quiet_time   <= next_quiet;
      second_tap_span  <= next_span;
      tap_flags        <= next_flags;
      tap_irq_pending  <= next_pending;
      hold_cnt         <= next_hold_cnt;
      reg_rdata        <= next_rdata;
    end
  end

  // ==========================================================
  // pad drivers; open-drain only pulls to the active-low level
  // registered so a control write never glitches a pad
  logic pad_one_act;
  logic pad_two_act;
  logic pad_one_lvl;
  logic pad_two_lvl;
  logic next_pad_one_o;
  logic next_pad_one_oe;
  logic next_pad_two_o;
  logic next_pad_two_oe;

  always_comb
  begin
    pad_one_act = pad_sel(irq_pad_control[TDEU_SEL_ONE_LSB +: 3], tap_line);
    pad_two_act = pad_sel(irq_pad_control[TDEU_SEL_TWO_LSB +: 3], tap_line);
    pad_one_lvl = pad_one_act ^ irq_pad_control[TDEU_POL_BIT];
    pad_two_lvl = pad_two_act ^ irq_pad_control[TDEU_POL_BIT];
    next_pad_one_o  = irq_pad_control[TDEU_DRV_BIT] ? 1'b0 : pad_one_lvl;
    next_pad_two_o  = irq_pad_control[TDEU_DRV_BIT] ? 1'b0 : pad_two_lvl;
    next_pad_one_oe = irq_pad_control[TDEU_DRV_BIT] ? ~pad_one_lvl : 1'b1;
    next_pad_two_oe = irq_pad_control[TDEU_DRV_BIT] ? ~pad_two_lvl : 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_pad_one_o  <= TDEU_RST_PAD_O;
      irq_pad_one_oe <= TDEU_RST_PAD_OE;
      irq_pad_two_o  <= TDEU_RST_PAD_O;
      irq_pad_two_oe <= TDEU_RST_PAD_OE;
    end
    else if (clk_en)
    begin
      irq_pad_one_o  <= next_pad_one_o;
      irq_pad_one_oe <= next_pad_one_oe;
      irq_pad_two_o  <= next_pad_two_o;
      irq_pad_two_oe <= next_pad_two_oe;
    end
  end

endmodule
`default_nettype wire

// ===== test/tdeu_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// port checker for the tap unit
module tdeu_top_sva
  import tdeu_pkg::*;
(
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_pad_one_o,
  input wire logic       irq_pad_one_oe,
  input wire logic       irq_pad_two_o,
  input wire logic       irq_pad_two_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // no clk_en term: it only drops around a span write, which nothing here watches
  // pads are registered, so pad checks look two edges after the write
  xy_readback_a: assert property (
    reg_wr && reg_addr == TDEU_ADDR_THR_XY ##1 !reg_wr && reg_addr == TDEU_ADDR_THR_XY
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("xy threshold readback wrong");
  len_readback_a: assert property (
    reg_wr && reg_addr == TDEU_ADDR_MAX_LEN ##1 !reg_wr && reg_addr == TDEU_ADDR_MAX_LEN
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("max length readback wrong");
  z_upper_zero_a: assert property (
    reg_addr == TDEU_ADDR_THR_Z |=> reg_rdata[7:4] == 4'h0) else $error("z upper bits set");
  src_top_zero_a: assert property (
    reg_addr == TDEU_ADDR_TAP_SRC |=> !reg_rdata[7]) else $error("source bit 7 set");
  push_pull_oe_a: assert property (
    reg_wr && reg_addr == TDEU_ADDR_PAD_CTRL && !reg_wdata[6]
    |=> ##1 irq_pad_one_oe && irq_pad_two_oe) else $error("push-pull pad not driven");
  open_drain_low_a: assert property (
    reg_wr && reg_addr == TDEU_ADDR_PAD_CTRL && reg_wdata[6]
    |=> ##1 !irq_pad_one_o && !irq_pad_two_o) else $error("open drain drives high");
  gnd_low_pol_a: assert property (
    reg_wr && reg_addr == TDEU_ADDR_PAD_CTRL && reg_wdata[7:6] == 2'h2
    && reg_wdata[2:0] == 3'h0 |=> ##1 irq_pad_one_o) else $error("idle pad one not high");
  gnd_two_high_a: assert property (
    reg_wr && reg_addr == TDEU_ADDR_PAD_CTRL && reg_wdata[7:6] == 2'h0
    && reg_wdata[5:3] == 3'h0 |=> ##1 !irq_pad_two_o) else $error("idle pad two not low");
endmodule
`default_nettype wire

// ===== test/tdeu_host_pads.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// host board pad with pull-up
module tdeu_host_pads (
  input  wire logic pad_o,
  input  wire logic pad_oe,
  output logic      pad_level
);
  // released pad floats to the pull-up, never to the last value
  assign pad_level = pad_oe ? pad_o : 1'b1;
endmodule
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tdeu_pkg::*;
  logic       mclk, arst_n, reg_wr, reg_rd, m_one, m_two, drdy;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ax, ay, az, d;
  logic       po_o, po_oe, pt_o, pt_oe, lvl_one, lvl_two, ce;
  int         errors, checks;

  tdeu_top dut (.mclk(mclk), .arst_n(arst_n), .clk_en(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .accel_x(ax), .accel_y(ay), .accel_z(az), .motion_source_one(m_one),
    .motion_source_two(m_two), .data_ready(drdy), .irq_pad_one_o(po_o),
    .irq_pad_one_oe(po_oe), .irq_pad_two_o(pt_o), .irq_pad_two_oe(pt_oe));
  tdeu_host_pads host_one (.pad_o(po_o), .pad_oe(po_oe), .pad_level(lvl_one));
  tdeu_host_pads host_two (.pad_o(pt_o), .pad_oe(pt_oe), .pad_level(lvl_two));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ==========================================================
  // shared tasks
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task conclude;
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read strobe also clears latched flags on the source register when the hold bit is set
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // short pulse, far inside any nonzero max length
  task tap(input int axis, input logic [7:0] v);
    @(posedge mclk);
    if (axis == 0) ax <= v;
    else if (axis == 1) ay <= v;
    else az <= v;
    repeat (3) @(posedge mclk);
    ax <= 8'h00;
    ay <= 8'h00;
    az <= 8'h00;
    repeat (6) @(posedge mclk);
  endtask

  // ==========================================================
  // scenarios
  task t_reset;
    logic [7:0] adr [8];
    adr = '{8'h22, 8'h38, 8'h39, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f};
    #1 check({6'h00, po_oe, po_o}, 8'h02);
    check({6'h00, pt_oe, pt_o}, 8'h02);
    foreach (adr[i]) rdc(adr[i], 8'h00);
  endtask

  task t_regs;
    wr(TDEU_ADDR_THR_XY, 8'h21);
    rdc(TDEU_ADDR_THR_XY, 8'h21);
    wr(TDEU_ADDR_THR_Z, 8'hf5);
    rdc(TDEU_ADDR_THR_Z, 8'h05);
    wr(TDEU_ADDR_MAX_LEN, 8'hff);
    rdc(TDEU_ADDR_MAX_LEN, 8'hff);
    wr(8'h40, 8'h55);
    rdc(8'h40, 8'h00);
    @(posedge mclk);
    ce <= 1'b0;
    wr(TDEU_ADDR_SPAN, 8'h11);
    ce <= 1'b1;
    rdc(TDEU_ADDR_SPAN, 8'h00);
  endtask

  task t_single;
    wr(TDEU_ADDR_THR_XY, 8'h43);
    wr(TDEU_ADDR_TAP_CFG, 8'h41);
    wr(TDEU_ADDR_MAX_LEN, 8'h02);
    wr(TDEU_ADDR_PAD_CTRL, 8'h07);
    tap(0, 8'h03);
    rdc(TDEU_ADDR_TAP_SRC, 8'h00);
    tap(0, 8'h04);
    check({7'h00, lvl_one}, 8'h01);
    rdc(TDEU_ADDR_TAP_SRC, 8'h41);
    rdc(TDEU_ADDR_TAP_SRC, 8'h00);
    check({7'h00, lvl_one}, 8'h00);
  endtask

  task t_len_gate;
    wr(TDEU_ADDR_MAX_LEN, 8'h00);
    tap(0, 8'h08);
    rdc(TDEU_ADDR_TAP_SRC, 8'h00);
    wr(TDEU_ADDR_MAX_LEN, 8'h02);
    wr(TDEU_ADDR_TAP_CFG, 8'h44);
    tap(0, 8'h08);
    rdc(TDEU_ADDR_TAP_SRC, 8'h00);
    tap(1, 8'h05);
    rdc(TDEU_ADDR_TAP_SRC, 8'h44);
    wr(TDEU_ADDR_THR_Z, 8'h0f);
    wr(TDEU_ADDR_TAP_CFG, 8'h50);
    tap(2, 8'h0f);
    rdc(TDEU_ADDR_TAP_SRC, 8'h00);
    tap(2, 8'h10);
    rdc(TDEU_ADDR_TAP_SRC, 8'h50);
  endtask

  // zero quiet time: second pulse inside span, then with no span at all
  task t_double;
    wr(TDEU_ADDR_QUIET, 8'h00);
    wr(TDEU_ADDR_SPAN, 8'h05);
    wr(TDEU_ADDR_TAP_CFG, 8'h42);
    tap(0, 8'h08);
    tap(0, 8'h08);
    rdc(TDEU_ADDR_TAP_SRC, 8'h42);
    wr(TDEU_ADDR_SPAN, 8'h00);
    tap(0, 8'h08);
    tap(0, 8'h08);
    rdc(TDEU_ADDR_TAP_SRC, 8'h00);
    wr(TDEU_ADDR_SPAN, 8'h05);
    wr(TDEU_ADDR_TAP_CFG, 8'h02);
    tap(0, 8'h08);
    tap(0, 8'h08);
    rdc(TDEU_ADDR_TAP_SRC, 8'h02);
    wr(TDEU_ADDR_TAP_CFG, 8'h42);
    rdc(TDEU_ADDR_TAP_SRC, 8'h02);
  endtask

  // second pulse lands deep inside a 255 ms quiet time
  task t_quiet;
    wr(TDEU_ADDR_QUIET, 8'hff);
    wr(TDEU_ADDR_SPAN, 8'hff);
    wr(TDEU_ADDR_TAP_CFG, 8'h42);
    tap(0, 8'h08);
    tap(0, 8'h08);
    rdc(TDEU_ADDR_TAP_SRC, 8'h00);
  endtask

  task t_pads;
    logic [2:0] code [6];
    logic       act [6];
    code = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    act = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    @(posedge mclk);
    m_two <= 1'b1;
    drdy <= 1'b1;
    for (int p = 0; p < 4; p++)
      foreach (code[i])
      begin
        wr(TDEU_ADDR_PAD_CTRL, {p[1], p[0], code[i], code[i]});
        repeat (4) @(posedge mclk);
        #1 check({7'h00, lvl_one}, {7'h00, act[i] ^ p[1]});
        check({7'h00, lvl_two}, {7'h00, act[i] ^ p[1]});
        if (!p[0]) check({7'h00, po_oe}, 8'h01);
        if (!p[0]) check({7'h00, pt_oe}, 8'h01);
      end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    {arst_n, reg_wr, reg_rd, m_one, m_two, drdy} = 6'h00;
    {reg_addr, reg_wdata, ax, ay, az} = 40'h0;
    ce = 1'b1;
    errors = 0;
    checks = 0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_regs();
    t_single();
    t_len_gate();
    t_double();
    t_quiet();
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_pads();
    conclude();
  end

  initial
  begin
    #(90000 * 8);
    errors++;
    conclude();
  end
endmodule

bind tdeu_top tdeu_top_sva chk (.mclk(mclk), .arst_n(arst_n), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .irq_pad_one_o(irq_pad_one_o), .irq_pad_one_oe(irq_pad_one_oe),
  .irq_pad_two_o(irq_pad_two_o), .irq_pad_two_oe(irq_pad_two_oe));
`default_nettype wire
